// ===== core/dmx_core.sv
// Summary of operation
// - indirect read loads W, sets zero
// - indirect write stores W, flags unchanged
// - window addresses redirect through matching pointer
// - mode 00/01/10/11 pre/post inc/dec
// - pre modes adjust first, post after
// - relative form adds signed offset, pointer kept
// - pointer ends +1, -1 or unchanged
// - pointers sixteen bits, wrap modulo 2^16
// - pointer update touches no flags
// - bank literal loads 5-bit bank select
// - latch literal loads 7-bit pc latch
// - acc literal loads W, flags unchanged
// - store copies W to file register
module dmx_core (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic [13:0] i_instr,
  input  wire logic        i_instr_valid,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  output logic      [7:0]  o_acc,
  output logic             o_zero,
  output logic      [4:0]  o_bank,
  output logic      [6:0]  o_pc_latch,
  output logic      [15:0] o_fp0,
  output logic      [15:0] o_fp1,
  output logic      [14:0] o_pc,
  output logic             o_busy,
  output logic             o_done
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic dmx_pkg::dmx_op_t decode(input logic [13:0] ins);
    dmx_pkg::dmx_op_t op;
    op = dmx_pkg::DMX_BAD;
    if (ins == dmx_pkg::OP_IDLE)                   op = dmx_pkg::DMX_IDLE;
    else if (ins[13:3] == dmx_pkg::OP_IRD_HI)      op = dmx_pkg::DMX_IRD;
    else if (ins[13:3] == dmx_pkg::OP_IWR_HI)      op = dmx_pkg::DMX_IWR;
    else if (ins[13:5] == dmx_pkg::OP_BANK_HI)     op = dmx_pkg::DMX_BANK;
    else if (ins[13:7] == dmx_pkg::OP_STORE_HI)    op = dmx_pkg::DMX_STORE;
    else if (ins[13:7] == dmx_pkg::OP_PCL_HI)      op = dmx_pkg::DMX_PCL;
    else if (ins[13:8] == dmx_pkg::OP_ACC_HI)      op = dmx_pkg::DMX_ACC;
    else if (ins[13:8] == dmx_pkg::OP_REL_HI) begin
      op = ins[7] ? dmx_pkg::DMX_IWR : dmx_pkg::DMX_IRD;
    end
    return op;
  endfunction

  typedef enum logic [0:0] {ST_RUN, ST_RD_WAIT} dmx_state_t;

  dmx_state_t        state_q;
  logic [7:0]        acc_q;
  logic              zero_q;
  logic [4:0]        bank_q;
  logic [6:0]        pcl_q;
  logic [15:0]       fp0_q;
  logic [15:0]       fp1_q;
  logic [14:0]       pc_q;
  logic              busy_q;
  logic              done_q;
  logic [7:0]        rdata_q;

  dmx_pkg::dmx_op_t  op;
  logic              take;
  logic              rel_form;
  logic              sel;
  logic [15:0]       sel_ptr;
  logic [15:0]       ea;
  logic [15:0]       ptr_next;
  logic              ind_upd;
  logic              win_store;

  dmx_mem_if mem_bus ();

  assign take     = i_ce && i_instr_valid && (state_q == ST_RUN);
  assign op       = decode(i_instr);
  assign rel_form = (i_instr[13:8] == dmx_pkg::OP_REL_HI);
  assign win_store = (op == dmx_pkg::DMX_STORE) &&
                     ((i_instr[6:0] == dmx_pkg::WIN0_ADDR) ||
                      (i_instr[6:0] == dmx_pkg::WIN1_ADDR));
  // pointer select: bit 0 for window store, bit 6 relative, else bit 2
  assign sel      = win_store ? i_instr[0] :
                    (rel_form ? i_instr[6] : i_instr[2]);
  assign sel_ptr  = sel ? fp1_q : fp0_q;
  assign ind_upd  = take && (op == dmx_pkg::DMX_IRD ||
                             op == dmx_pkg::DMX_IWR) && !rel_form;

  dmx_ptr_unit u_ptr (
    .i_ptr  (sel_ptr),
    .i_mode (i_instr[1:0]),
    .i_rel  (rel_form || win_store),
    .i_off  (win_store ? 6'h00 : i_instr[5:0]),
    .o_ea   (ea),
    .o_next (ptr_next)
  );

  dmx_data_mem u_mem (
    .i_clk (i_clk),
    .i_ce  (i_ce),
    .bus   (mem_bus.slave)
  );

  // ---------------------------------------------------------------
  // data memory access
  // ---------------------------------------------------------------
  always_comb begin
    mem_bus.re    = take && (op == dmx_pkg::DMX_IRD);
    mem_bus.we    = take && (op == dmx_pkg::DMX_IWR ||
                             op == dmx_pkg::DMX_STORE);
    mem_bus.wdata = acc_q;
    if (op == dmx_pkg::DMX_STORE && !win_store) begin
      mem_bus.addr = dmx_pkg::MEM_AW'({bank_q, i_instr[6:0]});
    end else begin
      mem_bus.addr = ea[dmx_pkg::MEM_AW-1:0];
    end
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= ST_RUN;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      pc_q    <= dmx_pkg::RST_PC;
    end else if (i_ce) begin
      done_q <= 1'b0;
      if (take) begin
        pc_q <= pc_q + 15'h0001;
        if (op == dmx_pkg::DMX_IRD) begin
          state_q <= ST_RD_WAIT;
          busy_q  <= 1'b1;
        end else begin
          done_q <= 1'b1;
        end
      end else if (state_q == ST_RD_WAIT) begin
        state_q <= ST_RUN;
        busy_q  <= 1'b0;
        done_q  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // working register and zero flag
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      acc_q  <= dmx_pkg::RST_BYTE;
      zero_q <= 1'b0;
    end else if (i_ce) begin
      if (state_q == ST_RD_WAIT) begin
        acc_q  <= mem_bus.rdata;
        zero_q <= (mem_bus.rdata == 8'h00);
      end else if (take && op == dmx_pkg::DMX_ACC) begin
        acc_q <= i_instr[7:0];
      end else if (i_wr && i_addr == dmx_pkg::REG_ACC) begin
        acc_q <= i_wdata;
      end else if (i_wr && i_addr == dmx_pkg::REG_STATUS) begin
        zero_q <= i_wdata[dmx_pkg::ZERO_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // bank select and pc latch
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bank_q <= dmx_pkg::RST_BYTE[4:0];
      pcl_q  <= dmx_pkg::RST_BYTE[6:0];
    end else if (i_ce) begin
      if (take && op == dmx_pkg::DMX_BANK) begin
        bank_q <= i_instr[4:0];
      end else if (i_wr && i_addr == dmx_pkg::REG_BANK) begin
        bank_q <= i_wdata[4:0];
      end
      if (take && op == dmx_pkg::DMX_PCL) begin
        pcl_q <= i_instr[6:0];
      end else if (i_wr && i_addr == dmx_pkg::REG_PCLAT) begin
        pcl_q <= i_wdata[6:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // file pointers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fp0_q <= dmx_pkg::RST_PTR;
      fp1_q <= dmx_pkg::RST_PTR;
    end else if (i_ce) begin
      // flags are left alone here by construction
      if (ind_upd && !sel) begin
        fp0_q <= ptr_next;
      end else if (i_wr && i_addr == dmx_pkg::REG_FP0_LO) begin
        fp0_q[7:0] <= i_wdata;
      end else if (i_wr && i_addr == dmx_pkg::REG_FP0_HI) begin
        fp0_q[15:8] <= i_wdata;
      end
      if (ind_upd && sel) begin
        fp1_q <= ptr_next;
      end else if (i_wr && i_addr == dmx_pkg::REG_FP1_LO) begin
        fp1_q[7:0] <= i_wdata;
      end else if (i_wr && i_addr == dmx_pkg::REG_FP1_HI) begin
        fp1_q[15:8] <= i_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= dmx_pkg::RST_BYTE;
    end else if (i_ce) begin
      rdata_q <= dmx_pkg::RST_BYTE;
      if (i_rd) begin
        case (i_addr)
          dmx_pkg::REG_ACC:    rdata_q <= acc_q;
          dmx_pkg::REG_STATUS: rdata_q <= {7'h00, zero_q};
          dmx_pkg::REG_BANK:   rdata_q <= {3'h0, bank_q};
          dmx_pkg::REG_PCLAT:  rdata_q <= {1'h0, pcl_q};
          dmx_pkg::REG_FP0_LO: rdata_q <= fp0_q[7:0];
          dmx_pkg::REG_FP0_HI: rdata_q <= fp0_q[15:8];
          dmx_pkg::REG_FP1_LO: rdata_q <= fp1_q[7:0];
          dmx_pkg::REG_FP1_HI: rdata_q <= fp1_q[15:8];
          dmx_pkg::REG_PC_LO:  rdata_q <= pc_q[7:0];
          dmx_pkg::REG_PC_HI:  rdata_q <= {1'h0, pc_q[14:8]};
          default:             rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign o_rdata    = rdata_q;
  assign o_acc      = acc_q;
  assign o_zero     = zero_q;
  assign o_bank     = bank_q;
  assign o_pc_latch = pcl_q;
  assign o_fp0      = fp0_q;
  assign o_fp1      = fp1_q;
  assign o_pc       = pc_q;
  assign o_busy     = busy_q;
  assign o_done     = done_q;

endmodule

// ===== core/dmx_pkg.sv
package dmx_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int IW      = 14;
  localparam int PTR_W   = 16;
  localparam int MEM_AW  = 12;
  localparam int PC_W    = 15;
  localparam int BUS_AW  = 4;

  // ---------------------------------------------------------------
  // instruction encodings (opcode bits above the operand fields)
  // ---------------------------------------------------------------
  localparam logic [13:0] OP_IDLE      = 14'h0000;
  localparam logic [6:0]  OP_STORE_HI  = 7'h01;   // instr[13:7]
  localparam logic [8:0]  OP_BANK_HI   = 9'h001;  // instr[13:5]
  localparam logic [6:0]  OP_PCL_HI    = 7'h63;   // instr[13:7]
  localparam logic [5:0]  OP_ACC_HI    = 6'h30;   // instr[13:8]
  localparam logic [10:0] OP_IRD_HI    = 11'h002; // instr[13:3]
  localparam logic [10:0] OP_IWR_HI    = 11'h003; // instr[13:3]
  localparam logic [5:0]  OP_REL_HI    = 6'h3f;   // instr[13:8]

  // ---------------------------------------------------------------
  // pointer update modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // ---------------------------------------------------------------
  // indirect window file addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] WIN0_ADDR = 7'h00;
  localparam logic [6:0] WIN1_ADDR = 7'h01;

  // ---------------------------------------------------------------
  // register map (word index) and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_ACC    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_BANK   = 4'h2;
  localparam logic [3:0] REG_PCLAT  = 4'h3;
  localparam logic [3:0] REG_FP0_LO = 4'h4;
  localparam logic [3:0] REG_FP0_HI = 4'h5;
  localparam logic [3:0] REG_FP1_LO = 4'h6;
  localparam logic [3:0] REG_FP1_HI = 4'h7;
  localparam logic [3:0] REG_PC_LO  = 4'h8;
  localparam logic [3:0] REG_PC_HI  = 4'h9;
  localparam int         ZERO_BIT   = 0;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_PTR   = 16'h0000;
  localparam logic [14:0] RST_PC    = 15'h0000;

  typedef enum logic [3:0] {
    DMX_IDLE, DMX_STORE, DMX_BANK, DMX_PCL, DMX_ACC,
    DMX_IRD, DMX_IWR, DMX_BAD
  } dmx_op_t;

endpackage

// ===== core/dmx_mem_if.sv
interface dmx_mem_if;
  logic                      we;
  logic                      re;
  logic [dmx_pkg::MEM_AW-1:0] addr;
  logic [7:0]                wdata;
  logic [7:0]                rdata;
  modport master (output we, output re, output addr, output wdata,
                  input rdata);
  modport slave  (input we, input re, input addr, input wdata,
                  output rdata);
endinterface

// ===== core/dmx_ptr_unit.sv
module dmx_ptr_unit (
  input  wire logic [15:0] i_ptr,
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_rel,
  input  wire logic [5:0]  i_off,
  output logic      [15:0] o_ea,
  output logic      [15:0] o_next
);
  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] rel;

  // modulo 2^16 wrap comes from the 16-bit width
  assign inc = i_ptr + 16'h0001;
  assign dec = i_ptr - 16'h0001;
  assign rel = i_ptr + {{10{i_off[5]}}, i_off};

  always_comb begin
    o_ea   = i_ptr;
    o_next = i_ptr;
    if (i_rel) begin
      o_ea   = rel;
      o_next = i_ptr;
    end else begin
      case (i_mode)
        dmx_pkg::MODE_PRE_INC: begin
          o_ea   = inc;
          o_next = inc;
        end
        dmx_pkg::MODE_PRE_DEC: begin
          o_ea   = dec;
          o_next = dec;
        end
        dmx_pkg::MODE_POST_INC: begin
          o_ea   = i_ptr;
          o_next = inc;
        end
        default: begin
          o_ea   = i_ptr;
          o_next = dec;
        end
      endcase
    end
  end
endmodule

// ===== core/dmx_data_mem.sv
module dmx_data_mem (
  input  wire logic i_clk,
  input  wire logic i_ce,
  dmx_mem_if.slave  bus
);
  localparam int DEPTH = 1 << dmx_pkg::MEM_AW;
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_q;

  always_ff @(posedge i_clk) begin
    if (i_ce && bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce && bus.re) begin
      rdata_q <= mem[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule

// ===== testbench/dmx_core_sva.sv
module dmx_core_sva (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic [13:0] i_instr,
  input  wire logic        i_instr_valid,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  o_rdata,
  input  wire logic [7:0]  o_acc,
  input  wire logic        o_zero,
  input  wire logic [4:0]  o_bank,
  input  wire logic [6:0]  o_pc_latch,
  input  wire logic [15:0] o_fp0,
  input  wire logic [15:0] o_fp1,
  input  wire logic [14:0] o_pc,
  input  wire logic        o_busy,
  input  wire logic        o_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  logic        tk;
  logic        ird;
  logic        ind;
  logic        lit;
  logic [15:0] sel;
  assign tk  = i_instr_valid && i_ce && !o_busy;
  assign ird = i_instr[13:3] == 11'h002;
  assign ind = ird || i_instr[13:3] == 11'h003;
  assign lit = i_instr[13:8] == 6'h30 || i_instr[13:7] == 7'h63 ||
               i_instr[13:5] == 9'h001 || i_instr[13:7] == 7'h01 ||
               i_instr == 14'h0000;
  assign sel = i_instr[2] ? o_fp1 : o_fp0;

  sequence s_ird_take;
    tk && ird;
  endsequence
  sequence s_ird_end;
    o_busy ##1 (!o_busy && o_done);
  endsequence

  a_ird_two_cycle: assert property (
    s_ird_take |=> s_ird_end)
    else $error("indirect read did not finish in two cycles");
  a_ird_zero_flag: assert property (
    s_ird_take ##2 1'b1 |-> o_zero == (o_acc == 8'h00))
    else $error("zero flag wrong after read");
  a_ptr_step: assert property (
    tk && ind |=>
    (($past(i_instr[2]) ? o_fp1 : o_fp0) == $past(sel) +
    ($past(i_instr[0]) ? 16'hffff : 16'h0001)))
    else $error("pointer not stepped by one");
  a_iwr_flags_kept: assert property (
    tk && ind && !ird && !i_wr |=> $stable(o_zero))
    else $error("indirect write changed zero flag");
  a_acc_lit_load: assert property (
    tk && i_instr[13:8] == 6'h30 |=>
    o_acc == $past(i_instr[7:0]) && o_done)
    else $error("acc literal not loaded");
  a_bank_lit_load: assert property (
    tk && i_instr[13:5] == 9'h001 |=> o_bank == $past(i_instr[4:0]))
    else $error("bank literal not loaded");
  a_pcl_lit_load: assert property (
    tk && i_instr[13:7] == 7'h63 |=> o_pc_latch == $past(i_instr[6:0]))
    else $error("pc latch not loaded");
  a_simple_one_cycle: assert property (
    tk && lit && !i_wr |=>
    o_done && $stable(o_zero) && o_pc == $past(o_pc) + 15'h0001)
    else $error("simple op not one cycle or flags moved");
  a_rel_ptr_kept: assert property (
    tk && i_instr[13:8] == 6'h3f && !i_wr |=>
    $stable(o_fp0) && $stable(o_fp1))
    else $error("relative move changed a pointer");
  a_rdata_idle_zero: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside read");
endmodule

bind dmx_core dmx_core_sva dmx_core_sva_i (.i_clk, .i_srst, .i_ce, .i_instr,
  .i_instr_valid, .i_wr, .i_rd, .o_rdata, .o_acc, .o_zero, .o_bank,
  .o_pc_latch, .o_fp0, .o_fp1, .o_pc, .o_busy, .o_done);

// ===== testbench/dmx_core_tb.sv
module dmx_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %0t: got %h exp %h", $time, g, e); \
  end end

  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_ce = 1'b1;
  logic [13:0] i_instr = 14'h0000;
  logic        i_instr_valid = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  wire  [7:0]  o_rdata, o_acc;
  wire  [4:0]  o_bank;
  wire  [6:0]  o_pc_latch;
  wire  [15:0] o_fp0, o_fp1;
  wire  [14:0] o_pc;
  wire         o_zero, o_busy, o_done;
  logic [7:0]  exp_q[$];
  logic [7:0]  e_now;
  logic        rd_seen = 1'b0;
  logic [14:0] pcn = 15'h0000;
  logic        zf = 1'b0;
  int          miscompares = 0;
  int          cmp_count = 0;

  dmx_core dmx_core_i (.i_clk, .i_srst, .i_ce, .i_instr, .i_instr_valid,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_acc, .o_zero, .o_bank,
    .o_pc_latch, .o_fp0, .o_fp1, .o_pc, .o_busy, .o_done);

  always #20 i_clk = ~i_clk;

  // ---------------------------------------------------------------
  // read monitor: oldest note against data one cycle after strobe
  // ---------------------------------------------------------------
  always @(posedge i_clk) rd_seen <= i_rd && i_ce && !i_srst;
  always @(negedge i_clk) begin
    if (rd_seen) begin
      e_now = exp_q.pop_front();
      `CHK(o_rdata, e_now)
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  task automatic ex(input logic [13:0] ins);
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr <= ins;
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    pcn++;
  endtask

  task automatic setp(input logic n, input logic [15:0] p);
    wr(n ? 4'h6 : 4'h4, p[7:0]);
    wr(n ? 4'h7 : 4'h5, p[15:8]);
  endtask

  task automatic chkp(input logic n, input logic [15:0] p);
    rd(n ? 4'h6 : 4'h4, p[7:0]);
    rd(n ? 4'h7 : 4'h5, p[15:8]);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge i_clk);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    logic [7:0]  v;
    logic [15:0] p;
    logic [15:0] nx;
    logic [15:0] ea;
    logic [1:0]  mm;
    logic        n;
    void'($urandom(26));
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    wr(4'hf, 8'h5a);
    wr(4'h8, 8'h33);
    for (int r = 0; r < 16; r++) rd(r[3:0], 8'h00);
    $display("reset and map test done");
    wr(4'h1, 8'h01);
    zf = 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hff : 8'($urandom);
      ex({6'h30, v});
      ex({9'h001, v[4:0]});
      ex({7'h63, v[6:0]});
      rd(4'h0, v);
      rd(4'h2, {3'h0, v[4:0]});
      rd(4'h3, {1'b0, v[6:0]});
      rd(4'h1, {7'h00, zf});
    end
    $display("literal test done");
    for (int m = 0; m < 8; m++) begin
      n = m[2];
      mm = m[1:0];
      p = n ? 16'($urandom) : (mm[0] ? 16'h0000 : 16'hffff);
      v = (m == 3) ? 8'h00 : 8'($urandom);
      nx = mm[0] ? p - 16'h0001 : p + 16'h0001;
      ea = mm[1] ? p : nx;
      ex({6'h30, v});
      setp(n, p);
      ex({11'h003, n, mm});
      chkp(n, nx);
      rd(4'h1, {7'h00, zf});
      ex({6'h30, ~v});
      setp(n, p);
      ex({11'h002, n, mm});
      zf = (v == 8'h00);
      rd(4'h0, v);
      rd(4'h1, {7'h00, zf});
      chkp(n, nx);
      $display("indirect test mode %0d done", m);
    end
    p = 16'($urandom);
    setp(1'b1, p);
    ex({6'h30, 8'ha5});
    ex(14'h0081);
    chkp(1'b1, p);
    ex({6'h30, 8'h00});
    ex({11'h002, 1'b1, 2'h2});
    rd(4'h0, 8'ha5);
    // relative write at fp0 - 32, read back through fp1 with offset 0
    p = 16'($urandom);
    v = 8'($urandom);
    setp(1'b0, p);
    ex({6'h30, v});
    ex({6'h3f, 2'b10, 6'h20});
    ex({6'h30, ~v});
    setp(1'b1, p - 16'h0020);
    ex({6'h3f, 2'b01, 6'h00});
    zf = (v == 8'h00);
    rd(4'h0, v);
    rd(4'h1, {7'h00, zf});
    chkp(1'b0, p);
    chkp(1'b1, p - 16'h0020);
    $display("relative test done");
    v = 8'($urandom);
    p = 16'($urandom);
    p[11:6] = 6'h3f;
    ex({9'h001, p[11:7]});
    ex({6'h30, v});
    ex({7'h01, p[6:0]});
    setp(1'b0, {4'h0, p[11:0]});
    ex({6'h30, ~v});
    ex({11'h002, 1'b0, 2'h2});
    rd(4'h0, v);
    $display("store test done");
    ex(14'h0000);
    @(posedge i_clk);
    i_ce <= 1'b0;
    ex({6'h30, 8'h11});
    pcn--;
    i_ce <= 1'b1;
    rd(4'h0, v);
    rd(4'h8, pcn[7:0]);
    rd(4'h9, {1'b0, pcn[14:8]});
    $display("idle and freeze test done");
    repeat (3) @(posedge i_clk);
    finish_test();
  end
endmodule
